// [include/acp_params.svh]
// constants for the autoclass and power-cut control block
// assumes 8-bit command codes and 0.5 W power units throughout
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// ==================== register map ====================
`define ACP_REG_CLASS_BASE 8'h4c
`define ACP_REG_CTRL 8'h50
`define ACP_REG_PWR_BASE 8'h51
`define ACP_CTRL_RESET 8'h00
`define ACP_CTRL_REQ_LSB 4

// ==================== class, level and allocation codes ====================
`define ACP_CLS_UNKNOWN 4'h0
`define ACP_CLS_ZERO 4'h6
`define ACP_CLS_SS5 4'h8
`define ACP_CLS_SS8 4'hb
`define ACP_CLS_DS5 4'hd
`define ACP_LVL_ZERO_GRANT 4'h3
`define ACP_LVL_ALLOC_BASE 4'h3
`define ACP_ALLOC_15W4 3'h0

// ==================== margin bands, 0.5 W units ====================
`define ACP_BAND_1 9'h025
`define ACP_BAND_2 9'h033
`define ACP_BAND_3 9'h049
`define ACP_BAND_4 9'h05a
`define ACP_BAND_5 9'h067
`define ACP_BAND_6 9'h074
`define ACP_BAND_7 9'h07e
`define ACP_BAND_8 9'h088
`define ACP_BAND_9 9'h092

`endif

// [include/acp_pkg.sv]
// types for the autoclass and power-cut control block
// assumes acp_params.svh supplies all numeric constants
package acp_pkg;

  // ==================== host register access ====================
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acp_reg_req_t;

  // ==================== per-channel events from the port engine ======
  typedef struct packed {
    logic turn_on;
    logic turn_off;
    logic class_done;
    logic ac_done;
    logic semi_auto;
    logic det_en;
    logic cls_en;
    logic manual_mode;
    logic one_finger;
    logic [2:0] alloc;
    logic [3:0] req_class;
    logic [3:0] prior_req;
    logic [6:0] ac_power;
  } acp_chan_in_t;

  // ==================== per-channel results ====================
  typedef struct packed {
    logic ac_start;
    logic class_complete;
    logic cut_wr;
    logic [8:0] cut_value;
  } acp_chan_out_t;

endpackage

// [rtl/acp_power_cut_ctrl.sv]
// autoclass request, class reporting and power-cut threshold update
// assumes port engine events are one-cycle pulses on i_clk_sys
`timescale 1ns/1ps
`include "acp_params.svh"

module acp_power_cut_ctrl import acp_pkg::*; (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // host register port
  input wire acp_reg_req_t i_reg,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // channel events and port wiring
  input wire acp_chan_in_t [3:0] i_chan,
  input wire logic [1:0] i_four_pair,
  input wire logic [1:0] i_single_sig,
  // channel results
  output acp_chan_out_t [3:0] o_chan,
  // 4-pair threshold writes per port
  output logic [1:0] o_four_cut_wr,
  output logic [1:0][8:0] o_four_cut_value
);

  // ==================== helpers ====================
  function automatic logic [3:0] cls_level(input logic [3:0] code);
    logic [3:0] lvl;
    lvl = 4'h0;
    if (code >= 4'h1 && code <= 4'h4) begin
      lvl = code;
    end else if (code >= `ACP_CLS_SS5 && code <= `ACP_CLS_SS8) begin
      lvl = code - 4'h3;
    end else if (code == `ACP_CLS_DS5) begin
      lvl = 4'h5;
    end
    return lvl;
  endfunction

  function automatic logic [3:0] cls_code(input logic [3:0] lvl,
                                          input logic dual);
    logic [3:0] c;
    c = lvl;
    if (lvl >= 4'h5) begin
      c = dual ? `ACP_CLS_DS5 : lvl + 4'h3;
    end
    return c;
  endfunction

  function automatic logic [8:0] margin(input logic [8:0] p);
    logic [8:0] m;
    if (p < `ACP_BAND_1) m = 9'h001;
    else if (p <= `ACP_BAND_2) m = 9'h002;
    else if (p <= `ACP_BAND_3) m = 9'h004;
    else if (p <= `ACP_BAND_4) m = 9'h006;
    else if (p <= `ACP_BAND_5) m = 9'h008;
    else if (p <= `ACP_BAND_6) m = 9'h00a;
    else if (p <= `ACP_BAND_7) m = 9'h00c;
    else if (p <= `ACP_BAND_8) m = 9'h00e;
    else if (p <= `ACP_BAND_9) m = 9'h010;
    else m = 9'h012;
    return m;
  endfunction

  // upper power of each granted class, 0.5 W units
  function automatic logic [8:0] cls_limit(input logic [3:0] lvl);
    logic [8:0] l;
    unique case (lvl)
      4'h1: l = 9'h008;
      4'h2: l = 9'h00e;
      4'h3: l = 9'h01e;
      4'h4: l = 9'h03c;
      4'h5: l = 9'h05a;
      4'h6: l = 9'h078;
      4'h7: l = 9'h096;
      4'h8: l = 9'h0b4;
      default: l = 9'h000;
    endcase
    return l;
  endfunction

  // ==================== state ====================
  logic [3:0] req_ff;
  logic [3:0] aac_ff;
  logic [3:0] on_ff;
  logic [3:0] busy_ff;
  logic [3:0] got_ff;
  logic [3:0] upd_ff;
  logic [3:0][3:0] gcls_ff;
  logic [3:0][3:0] pcls_ff;
  logic [3:0][6:0] pwr_ff;
  acp_chan_out_t [3:0] out_ff;
  logic [1:0] four_wr_ff;
  logic [1:0][8:0] four_val_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [3:0] ss4;
  logic [3:0] start_ok;
  logic [3:0][3:0] grant;
  logic [3:0] pvalid;
  logic [1:0] port_fire;
  logic ctrl_wr;

  assign ctrl_wr = i_reg.wr && i_reg.addr == `ACP_REG_CTRL;

  // ==================== per channel ====================
  for (genvar ch = 0; ch < 4; ch++) begin : g_ch
    localparam int PT = ch / 2;
    localparam int PR = ch ^ 1;
    logic [3:0] lvl;
    logic [3:0] alim;
    logic [8:0] pw;
    logic [8:0] cut;

    assign ss4[ch] = i_four_pair[PT] & i_single_sig[PT];
    assign pvalid[ch] = i_chan[ch].semi_auto & i_chan[ch].det_en &
                        i_chan[ch].cls_en;
    assign start_ok[ch] = req_ff[ch] & on_ff[ch] & ~busy_ff[ch] &
                          (~ss4[ch] |
                           (req_ff[PR] & on_ff[PR] & ~busy_ff[PR]));

    always_comb begin
      lvl = cls_level(i_chan[ch].req_class);
      if (i_chan[ch].req_class == `ACP_CLS_ZERO) begin
        lvl = `ACP_LVL_ZERO_GRANT;
      end
      alim = {1'b0, i_chan[ch].alloc} + `ACP_LVL_ALLOC_BASE;
      if (alim < lvl) begin
        lvl = alim;
      end
      grant[ch] = cls_code(lvl, i_four_pair[PT] & ~i_single_sig[PT]);
    end

    assign pw = {2'b00, pwr_ff[ch]};
    assign cut = pw + margin(pw);

    // control bits: host write wins over hardware clear
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        req_ff[ch] <= 1'b0;
        aac_ff[ch] <= 1'b0;
      end else if (ctrl_wr) begin
        req_ff[ch] <= i_reg.wdata[`ACP_CTRL_REQ_LSB + ch];
        aac_ff[ch] <= i_reg.wdata[ch];
      end else if (i_chan[ch].turn_on) begin
        req_ff[ch] <= 1'b0;
      end else if (upd_ff[ch]) begin
        req_ff[ch] <= 1'b0;
      end
    end

    // powered state and measurement bookkeeping
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        on_ff[ch] <= 1'b0;
        busy_ff[ch] <= 1'b0;
        got_ff[ch] <= 1'b0;
        upd_ff[ch] <= 1'b0;
      end else begin
        upd_ff[ch] <= i_chan[ch].ac_done;
        if (i_chan[ch].turn_off) begin
          on_ff[ch] <= 1'b0;
          busy_ff[ch] <= 1'b0;
          got_ff[ch] <= 1'b0;
        end else begin
          if (i_chan[ch].turn_on) begin
            on_ff[ch] <= 1'b1;
          end
          // stay busy until the request bit clears, else it fires again
          if (start_ok[ch]) begin
            busy_ff[ch] <= 1'b1;
          end else if (upd_ff[ch]) begin
            busy_ff[ch] <= 1'b0;
          end
          if (i_chan[ch].ac_done && ss4[ch]) begin
            got_ff[ch] <= 1'b1;
          end else if (port_fire[PT]) begin
            got_ff[ch] <= 1'b0;
          end
        end
      end
    end

    // granted and prior class codes
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        gcls_ff[ch] <= `ACP_CLS_UNKNOWN;
        pcls_ff[ch] <= `ACP_CLS_UNKNOWN;
      end else if (i_chan[ch].turn_off) begin
        gcls_ff[ch] <= `ACP_CLS_UNKNOWN;
        pcls_ff[ch] <= `ACP_CLS_UNKNOWN;
      end else begin
        if (i_chan[ch].turn_on && !i_chan[ch].manual_mode) begin
          gcls_ff[ch] <= grant[ch];
        end else if (ss4[ch] && i_chan[PR].turn_on &&
                     !i_chan[PR].manual_mode) begin
          gcls_ff[ch] <= grant[PR];
        end
        if (i_chan[ch].turn_on && i_chan[ch].one_finger &&
            i_chan[ch].alloc == `ACP_ALLOC_15W4 && pvalid[ch]) begin
          pcls_ff[ch] <= i_chan[ch].prior_req;
        end
      end
    end

    // power result and 2-pair threshold writes
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pwr_ff[ch] <= 7'h00;
        out_ff[ch] <= '0;
      end else begin
        if (i_chan[ch].ac_done) begin
          pwr_ff[ch] <= i_chan[ch].ac_power;
        end
        out_ff[ch].ac_start <= start_ok[ch];
        out_ff[ch].class_complete <= i_chan[ch].class_done;
        out_ff[ch].cut_wr <= upd_ff[ch] & ~ss4[ch] & aac_ff[ch] &
          (cut <= cls_limit(cls_level(gcls_ff[ch])));
        if (upd_ff[ch] && !ss4[ch]) begin
          out_ff[ch].cut_value <= cut;
        end
      end
    end
  end

  // ==================== per 4-pair port ====================
  for (genvar pt = 0; pt < 2; pt++) begin : g_pt
    localparam int CA = 2 * pt;
    localparam int CB = 2 * pt + 1;
    logic [8:0] sum;
    logic [8:0] cut4;

    assign port_fire[pt] = got_ff[CA] & got_ff[CB];
    assign sum = {2'b00, pwr_ff[CA]} + {2'b00, pwr_ff[CB]};
    assign cut4 = sum + margin(sum);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        four_wr_ff[pt] <= 1'b0;
        four_val_ff[pt] <= 9'h000;
      end else begin
        four_wr_ff[pt] <= port_fire[pt] & (aac_ff[CA] | aac_ff[CB]) &
          (cut4 <= cls_limit(cls_level(gcls_ff[CA])));
        if (port_fire[pt]) begin
          four_val_ff[pt] <= cut4;
        end
      end
    end
  end

  // ==================== register read ====================
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= i_reg.rd;
      if (i_reg.rd) begin
        rdata_ff <= 8'h00;
        for (int c = 0; c < 4; c++) begin
          if (i_reg.addr == `ACP_REG_CLASS_BASE + 8'(c)) begin
            rdata_ff <= {gcls_ff[c],
                         pvalid[c] ? pcls_ff[c] : 4'h0};
          end
          if (i_reg.addr == `ACP_REG_PWR_BASE + 8'(c)) begin
            rdata_ff <= {1'b0, pwr_ff[c]};
          end
        end
        if (i_reg.addr == `ACP_REG_CTRL) begin
          rdata_ff <= {req_ff, aac_ff};
        end
      end
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
  assign o_chan = out_ff;
  assign o_four_cut_wr = four_wr_ff;
  assign o_four_cut_value = four_val_ff;

endmodule // acp_power_cut_ctrl

// [verification/acp_pcc_monitor.sv]
// checker for the autoclass power-cut block
// assumes it is bound to the top module ports
`timescale 1ns/1ps
module acp_pcc_monitor import acp_pkg::*; (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // watched ports
  input wire acp_reg_req_t i_reg,
  input wire logic o_reg_rvalid,
  input wire acp_chan_in_t [3:0] i_chan,
  input wire logic [1:0] i_four_pair,
  input wire logic [1:0] i_single_sig,
  input wire acp_chan_out_t [3:0] o_chan,
  input wire logic [1:0] o_four_cut_wr
);
  // ==================================================
  // properties
  logic p1_done;
  assign p1_done = i_chan[2].ac_done | i_chan[3].ac_done;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  rd_answer_a: assert property (i_reg.rd |=> o_reg_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (!i_reg.rd |=> !o_reg_rvalid)
    else $error("answer without read");
  cls_flag_a: assert property (i_chan[2].class_done |=>
    o_chan[2].class_complete) else $error("class flag missing");
  cls_only_a: assert property (!i_chan[3].class_done |=>
    !o_chan[3].class_complete) else $error("class flag unasked");
  cut_timing_a: assert property (o_chan[0].cut_wr |->
    $past(i_chan[0].ac_done, 2)) else $error("cut write off time");
  cut_margin_a: assert property (o_chan[0].cut_wr |->
    (o_chan[0].cut_value - {2'h0, $past(i_chan[0].ac_power, 2)})
    inside {[9'h001:9'h012]}) else $error("cut value off");
  four_only_a: assert property (i_four_pair[1] && i_single_sig[1] |->
    !o_chan[2].cut_wr && !o_chan[3].cut_wr) else $error("2-pair cut");
  four_timing_a: assert property (o_four_cut_wr[1] |->
    $past(p1_done, 2)) else $error("4-pair cut off time");
  rd_c: cover property (o_reg_rvalid);
  cut_c: cover property (o_chan[0].cut_wr);
  four_c: cover property (o_four_cut_wr[1]);
endmodule // acp_pcc_monitor

// [verification/acp_port_model.sv]
// port engine stand-in answering autoclass starts
// assumes one measurement per channel at a time
`timescale 1ns/1ps
module acp_port_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // starts and result table
  input wire logic [3:0] i_start,
  input wire logic [3:0][6:0] i_pwr,
  // results
  output logic [3:0] o_done,
  output logic [3:0][6:0] o_pwr
);
  logic [3:0][3:0] cnt_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
      o_done <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        o_done[c] <= cnt_ff[c] == 4'h1;
        if (i_start[c]) cnt_ff[c] <= 4'(3 + 2 * c);
        else if (cnt_ff[c] != 4'h0) cnt_ff[c] <= cnt_ff[c] - 4'h1;
      end
    end
  end
  // power valid only with done
  always_comb begin
    for (int c = 0; c < 4; c++) o_pwr[c] = o_done[c] ? i_pwr[c] : ~i_pwr[c];
  end
endmodule // acp_port_model

// [verification/acp_testbench.sv]
// self-checking bench for the autoclass power-cut block
// assumes the port model answers every start
`timescale 1ns/1ps
module testbench import acp_pkg::*;;
  logic clk, rst_n, rv;
  logic [4:0] hit;
  acp_reg_req_t req;
  acp_chan_in_t [3:0] ch, chan;
  acp_chan_out_t [3:0] oc;
  logic [1:0] fp, ss, fw;
  logic [1:0][8:0] fv;
  logic [7:0] rd;
  logic [3:0] done, st;
  logic [3:0][6:0] pw, ppw;
  logic [8:0] v;
  int n_mismatch, n_tests;
  always_comb begin
    chan = ch;
    for (int c = 0; c < 4; c++) begin
      chan[c].ac_done = done[c];
      chan[c].ac_power = ppw[c];
      st[c] = oc[c].ac_start;
    end
  end
  acp_power_cut_ctrl DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_reg(req),
    .o_reg_rdata(rd), .o_reg_rvalid(rv), .i_chan(chan), .i_four_pair(fp),
    .i_single_sig(ss), .o_chan(oc), .o_four_cut_wr(fw),
    .o_four_cut_value(fv));
  acp_port_model u_pm (.i_clk_sys(clk), .i_rst_n(rst_n), .i_start(st),
    .i_pwr(pw), .o_done(done), .o_pwr(ppw));
  // ==================================================
  // helpers
  task tick();
    @(posedge clk);
    #1;
  endtask
  task chk(input string n, input logic [8:0] e, input logic [8:0] s);
    n_tests++;
    if (e !== s) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick();
    req.wr = 1'b0;
    tick();
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    req.rd = 1'b1;
    req.addr = a;
    tick();
    req.rd = 1'b0;
    chk("rvalid", 9'h001, {8'h00, rv});
    chk("rdata", {1'b0, e}, {1'b0, rd});
    tick();
  endtask
  task on(input int c, input logic [3:0] rq, input logic [2:0] al);
    ch[c].req_class = rq;
    ch[c].alloc = al;
    ch[c].turn_on = 1'b1;
    tick();
    ch[c].turn_on = 1'b0;
    tick();
  endtask
  // s below 4 picks a channel, else a port
  task wcut(input int s);
    hit = 5'h00;
    v = '0;
    repeat (30) begin
      tick();
      if ((s < 4 ? oc[s].cut_wr : fw[s-4]) === 1'b1) begin
        hit = hit + 5'h01;
        v = s < 4 ? oc[s].cut_value : fv[s-4];
      end
    end
  endtask
  function automatic logic [8:0] mg(input logic [8:0] p);
    return p < 9'h025 ? 9'h001 : p <= 9'h033 ? 9'h002 : p <= 9'h049 ?
      9'h004 : p <= 9'h05a ? 9'h006 : p <= 9'h067 ? 9'h008 : p <= 9'h074 ?
      9'h00a : p <= 9'h07e ? 9'h00c : p <= 9'h088 ? 9'h00e : p <= 9'h092 ?
      9'h010 : 9'h012;
  endfunction
  // ==================================================
  // scenarios
  task t_ctrl();
    rdc(8'h50, 8'h00);
    wr(8'h50, 8'hff);
    rdc(8'h50, 8'hff);
    rdc(8'h60, 8'h00);
  endtask
  task t_class();
    ch[1].semi_auto = 1'b1;
    ch[1].det_en = 1'b1;
    ch[1].cls_en = 1'b1;
    ch[1].one_finger = 1'b1;
    ch[1].prior_req = 4'h2;
    on(1, 4'h3, 3'h0);
    rdc(8'h4d, 8'h32);
    ch[1].det_en = 1'b0;
    rdc(8'h4d, 8'h30);
    on(0, 4'h6, 3'h1);
    rdc(8'h4c, 8'h30);
    ch[0].turn_off = 1'b1;
    tick();
    ch[0].turn_off = 1'b0;
    rdc(8'h4c, 8'h00);
    ch[2].manual_mode = 1'b1;
    on(2, 4'h3, 3'h1);
    rdc(8'h4e, 8'h00);
    ch[2].manual_mode = 1'b0;
  endtask
  task automatic t_bands();
    logic [6:0] bp [8] = '{7'h24, 7'h25, 7'h33, 7'h49, 7'h5a, 7'h74,
      7'h88, 7'h93};
    wr(8'h50, 8'h10);
    on(0, 4'hb, 3'h5);
    rdc(8'h50, 8'h00);
    foreach (bp[i]) begin
      pw[0] = bp[i];
      wr(8'h50, 8'h11);
      wcut(0);
      chk("cut", {2'h0, bp[i]} + mg({2'h0, bp[i]}), v);
      chk("cut count", 9'h001, {4'h0, hit});
      rdc(8'h51, {1'b0, bp[i]});
      rdc(8'h50, 8'h01);
    end
    wr(8'h50, 8'h10);
    wcut(0);
    chk("no enable", 9'h000, {4'h0, hit});
  endtask
  task t_range();
    on(0, 4'h1, 3'h1);
    pw[0] = 7'h14;
    wr(8'h50, 8'h11);
    wcut(0);
    chk("over range", 9'h000, {4'h0, hit});
  endtask
  task t_four();
    fp = 2'b11;
    ss = 2'b10;
    on(1, 4'h8, 3'h5);
    rdc(8'h4d, 8'hd0);
    rdc(8'h4c, 8'h10);
    on(2, 4'h8, 3'h2);
    rdc(8'h4f, 8'h80);
    on(3, 4'h8, 3'h2);
    rdc(8'h4e, 8'h80);
    ch[2].class_done = 1'b1;
    tick();
    ch[2].class_done = 1'b0;
    chk("flag2", 9'h001, {8'h00, oc[2].class_complete});
    chk("flag3", 9'h000, {8'h00, oc[3].class_complete});
    wr(8'h50, 8'h44);
    wcut(5);
    chk("one request", 9'h000, {4'h0, hit});
    pw[2] = 7'h14;
    pw[3] = 7'h18;
    wr(8'h50, 8'hc4);
    wcut(5);
    chk("four cut", 9'h02c + mg(9'h02c), v);
    chk("four count", 9'h001, {4'h0, hit});
  endtask
  task test_done();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, req, ch, fp, ss, pw, n_mismatch, n_tests} = '0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    t_ctrl();
    t_class();
    t_bands();
    t_range();
    t_four();
    test_done();
  end
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule // testbench
bind acp_power_cut_ctrl acp_pcc_monitor u_mon (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_reg(i_reg), .o_reg_rvalid(o_reg_rvalid),
  .i_chan(i_chan), .i_four_pair(i_four_pair), .i_single_sig(i_single_sig),
  .o_chan(o_chan), .o_four_cut_wr(o_four_cut_wr));
